// [emsd_defines.svh]
// What this block does
// - Four space selects decoded from address 31:28
// - At most one space select active
// - Eight lane enables from low address bits
// - Lane count follows configured memory width
// - Lane enables act as byte write strobes
// - Lane enables drive SDRAM data masks directly
// - Drive peripheral transfer strobe between peripherals
`ifndef EMSD_DEFINES_SVH
`define EMSD_DEFINES_SVH
`define EMSD_ADDR_W      32
`define EMSD_SPACE_LSB   28
`define EMSD_SPACE_MSB   31
`define EMSD_NUM_SPACES  4
`define EMSD_NUM_LANES   8
`define EMSD_SEL_IDLE    4'hF
`define EMSD_LANE_IDLE   8'hFF
`define EMSD_STROBE_IDLE 1'b1
`define EMSD_WRITE_IDLE  1'b0
`endif

// [emsd_pkg.sv]
package emsd_pkg;
    // External memory width configuration
    typedef enum logic [1:0]
    {
        EMSD_W8  = 2'h0,
        EMSD_W16 = 2'h1,
        EMSD_W32 = 2'h2,
        EMSD_W64 = 2'h3
    } emsd_width_type;
    // Access sequencing
    typedef enum {EMSD_IDLE, EMSD_ACTIVE} emsd_state_type;
endpackage

// [emsd_lane_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emsd_defines.svh"
interface emsd_lane_if;
    logic [2:0]                 addr_lo;
    emsd_pkg::emsd_width_type   width;
    logic [`EMSD_NUM_LANES-1:0] size_mask;
    logic [`EMSD_NUM_LANES-1:0] lanes;
    modport dec (input addr_lo, input width, input size_mask,
                 output lanes);
    modport top (output addr_lo, output width, output size_mask,
                 input lanes);
endinterface
`default_nettype wire

// [emsd_lane_dec.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emsd_defines.svh"
module emsd_lane_dec
(
    emsd_lane_if.dec lif
);
    wire [3:0] lanes_per_word;
    wire [2:0] lane_base;
    // Lanes per memory word and base lane index within it
    assign lanes_per_word = 4'h1 << lif.width;
    assign lane_base = lif.addr_lo & ~(3'(lanes_per_word) - 3'h1);
    // Lane base+k carries mask bit k for k below lanes_per_word, so
    // a narrow memory never sees more than its own count of enables
    // and lanes outside the addressed word stay off
    genvar g;
    generate
        for (g = 0; g < `EMSD_NUM_LANES; g = g + 1)
        begin : g_lane
            wire [3:0] rel;
            assign rel = 4'(g) - {1'b0, lane_base};
            // Lanes below the base wrap rel past 8 and drop out
            assign lif.lanes[g] = (rel < lanes_per_word)
                && lif.size_mask[rel[2:0]];
        end
    endgenerate
endmodule
`default_nettype wire

// [emsd_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emsd_defines.svh"
module emsd_top
(
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    input  wire logic                        i_req,
    input  wire logic                        i_write,
    input  wire logic                        i_periph_xfer,
    input  wire logic [`EMSD_ADDR_W-1:0]     i_addr,
    input  wire logic [`EMSD_NUM_LANES-1:0]  i_byte_mask,
    input  wire emsd_pkg::emsd_width_type    i_width,
    output logic [`EMSD_NUM_SPACES-1:0]      o_space_sel_n,
    output logic [`EMSD_NUM_LANES-1:0]       o_lane_en_n,
    output logic                             o_periph_xfer_strobe_n,
    output logic                             o_write_r
);
    emsd_lane_if lif ();
    // Pin registers
    logic [`EMSD_NUM_SPACES-1:0] space_sel_n_r;
    logic [`EMSD_NUM_LANES-1:0]  lane_en_n_r;
    logic                        pdt_n_r;
    logic                        write_r;
    // Decode nets, all combinational
    wire  [3:0]                  space_field;
    wire                         space_hit;
    wire  [`EMSD_NUM_SPACES-1:0] space_onehot;
    wire  [`EMSD_NUM_SPACES-1:0] space_sel_n_nxt;
    wire  [`EMSD_NUM_LANES-1:0]  lane_en_n_nxt;
    wire                         pdt_n_nxt;
    wire                         req_live;

    // Space decode from byte address top nibble
    assign space_field = i_addr[`EMSD_SPACE_MSB:`EMSD_SPACE_LSB];
    // Only codes 0..3 map to a space; others assert no select or strobe
    assign space_hit = i_req && (space_field < 4'(`EMSD_NUM_SPACES));
    // One comparator per space; distinct codes keep it one-hot
    genvar s;
    generate
        for (s = 0; s < `EMSD_NUM_SPACES; s = s + 1)
        begin : g_space
            assign space_onehot[s] = space_hit
                && (space_field[1:0] == 2'(s));
        end
    endgenerate
    assign space_sel_n_nxt = ~space_onehot;

    // Lane decode in the sub-module
    assign lif.addr_lo   = i_addr[2:0];
    assign lif.width     = i_width;
    assign lif.size_mask = i_byte_mask;
    // Sub-module holds the per-lane generate loop
    emsd_lane_dec u_lane
    (
        .lif (lif.dec)
    );
    // Same active-low lanes serve writes and SDRAM masks
    assign lane_en_n_nxt = i_req ? ~lif.lanes : `EMSD_LANE_IDLE;
    // Peripheral transfer: data bypasses us, only strobe driven
    assign pdt_n_nxt = ~(space_hit && i_periph_xfer);

    // Registered outputs avoid decode glitches on the pins
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            space_sel_n_r <= `EMSD_SEL_IDLE;
            lane_en_n_r   <= `EMSD_LANE_IDLE;
            pdt_n_r       <= `EMSD_STROBE_IDLE;
            write_r       <= `EMSD_WRITE_IDLE;
        end
        else
        begin
            space_sel_n_r <= space_sel_n_nxt;
            lane_en_n_r   <= lane_en_n_nxt;
            pdt_n_r       <= pdt_n_nxt;
            write_r       <= i_req && i_write;
        end
    end

    // Pins come straight from the registers
    assign o_space_sel_n          = space_sel_n_r;
    assign o_lane_en_n            = lane_en_n_r;
    assign o_periph_xfer_strobe_n = pdt_n_r;
    assign o_write_r              = write_r;

    // Checks below judge outputs one cycle after their inputs. An
    // edge taken while reset still stands shows idle pins whatever
    // the inputs were, and the disable may already have dropped in
    // that time step, so such starts are masked through req_live.
    assign req_live = i_req && !i_rst;

    // Two selects at once would fight over one device
    a_space_onehot: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        $onehot0(~o_space_sel_n))
        else $error("more than one space select active");

    // A valid code lands on its own select line
    a_space_decode: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_addr[31:28] < 4'h4) |=>
        !o_space_sel_n[$past(i_addr[29:28])])
        else $error("wrong space select");

    // Codes above three select nothing and fire no strobe
    a_space_refused: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_addr[31:28] >= 4'h4) |=>
        (o_space_sel_n == `EMSD_SEL_IDLE && o_periph_xfer_strobe_n))
        else $error("select for a refused code");

    // No access, no pins: selects and lanes rest high
    a_idle_quiet: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        !i_req |=> (o_space_sel_n == `EMSD_SEL_IDLE &&
        o_lane_en_n == `EMSD_LANE_IDLE))
        else $error("outputs active while idle");

    // Strobe and write copy rest too when nothing is requested
    a_pdt_idle: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        !i_req |=> (o_periph_xfer_strobe_n && !o_write_r))
        else $error("strobe or write while idle");

    // A select never shows without a request behind it
    a_sel_needs_req: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (o_space_sel_n != `EMSD_SEL_IDLE) |-> $past(i_req))
        else $error("select without request");

    // Nor does a lane enable
    a_lane_needs_req: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (o_lane_en_n != `EMSD_LANE_IDLE) |-> $past(i_req))
        else $error("lane enable without request");

    // Pins rest during reset and on the first edge after it
    a_reset_idle: assert property (@(posedge i_mclk)
        $past(i_rst) |-> (o_space_sel_n == `EMSD_SEL_IDLE &&
        o_lane_en_n == `EMSD_LANE_IDLE && o_periph_xfer_strobe_n &&
        !o_write_r))
        else $error("outputs active across reset");

    // An 8-bit memory takes one lane at most
    a_lane_width: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W8) |=>
        ($countones(~o_lane_en_n) <= 1))
        else $error("too many lanes for 8-bit memory");

    // A 16-bit memory takes two lanes at most
    a_lane_w16: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W16) |=>
        ($countones(~o_lane_en_n) <= 2))
        else $error("too many lanes for 16-bit memory");

    // A 32-bit memory takes four lanes at most
    a_lane_w32: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W32) |=>
        ($countones(~o_lane_en_n) <= 4))
        else $error("too many lanes for 32-bit memory");

    // On an 8-bit memory the byte offset alone picks the lane
    a_lane_byte: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W8) |=>
        (o_lane_en_n == ~(8'($past(i_byte_mask[0])) << $past(i_addr[2:0]))))
        else $error("byte lane does not follow offset");

    // A 16-bit access stays inside its addressed lane pair
    a_lane_in_word: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W16) |=>
        ((~o_lane_en_n & ~(8'h03 << {$past(i_addr[2:1]), 1'b0})) == 8'h00))
        else $error("lane outside addressed word");

    // Full-width memory follows the mask lane for lane
    a_lane_full: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_width == emsd_pkg::EMSD_W64) |=>
        (o_lane_en_n == ~$past(i_byte_mask)))
        else $error("64-bit lanes do not follow mask");

    // An empty mask writes nothing, though the write still shows
    a_lane_write: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_write && i_byte_mask == 8'h00) |=>
        (o_lane_en_n == `EMSD_LANE_IDLE) && o_write_r)
        else $error("lane written without mask");

    // Write qualifier pairs with the lanes of the same access
    a_write_copy: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        req_live |=> (o_write_r == $past(i_write)))
        else $error("write flag does not follow request");

    // Reads mask the same lanes, as an SDRAM mask pin expects
    a_sdram_mask: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && !i_write && i_width == emsd_pkg::EMSD_W64) |=>
        (o_lane_en_n == ~$past(i_byte_mask)))
        else $error("read mask lanes wrong");

    // A valid peripheral transfer fires the strobe
    a_pdt_fire: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_live && i_periph_xfer && i_addr[31:28] < 4'h4) |=>
        !o_periph_xfer_strobe_n)
        else $error("transfer strobe missing");

    // The strobe never shows without a selected space
    a_pdt_strobe: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        !o_periph_xfer_strobe_n |-> ($past(i_periph_xfer) &&
        o_space_sel_n != `EMSD_SEL_IDLE))
        else $error("transfer strobe without access");
endmodule
`default_nettype wire

// [emsd_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module emsd_mem_model
(
    input  wire logic       i_mclk,
    input  wire logic [3:0] i_space_sel_n,
    input  wire logic [7:0] i_lane_en_n,
    input  wire logic       i_write,
    output var  int         o_bytes_written,
    output var  logic       o_multi_sel
);
    initial o_bytes_written = 0;
    initial o_multi_sel = 1'b0;
    // Masked lanes are left alone, as an SDRAM mask pin would
    always @(posedge i_mclk)
    begin
        if (i_space_sel_n != 4'hF && i_write)
            o_bytes_written <= o_bytes_written + $countones(~i_lane_en_n);
        o_multi_sel <= o_multi_sel | ($countones(~i_space_sel_n) > 1);
    end
endmodule
`default_nettype wire

// [ext_mem_strobe_decode_test.sv]
`timescale 1ns/10ps
`default_nettype none
module ext_mem_strobe_decode_test;
    logic        i_mclk, i_rst, i_req, i_write, i_periph_xfer, o_write_r;
    logic [31:0] i_addr;
    logic [7:0]  i_byte_mask, o_lane_en_n;
    logic [1:0]  wid;
    logic [3:0]  o_space_sel_n;
    logic        o_periph_xfer_strobe_n, multi;
    logic [13:0] exp;
    int          error_cnt, total_checks, seed, bytes, exp_bytes, cyc = 0;
    emsd_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req),
        .i_write(i_write), .i_periph_xfer(i_periph_xfer), .i_addr(i_addr),
        .i_byte_mask(i_byte_mask), .i_width(emsd_pkg::emsd_width_type'(wid)),
        .o_space_sel_n(o_space_sel_n), .o_lane_en_n(o_lane_en_n),
        .o_periph_xfer_strobe_n(o_periph_xfer_strobe_n),
        .o_write_r(o_write_r));
    emsd_mem_model mem (.i_mclk(i_mclk), .i_space_sel_n(o_space_sel_n),
        .i_lane_en_n(o_lane_en_n), .i_write(o_write_r),
        .o_bytes_written(bytes), .o_multi_sel(multi));
    always #25 i_mclk = ~i_mclk;
    // Hang guard, well above the 404 cycles the run needs
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task wrap_up();
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Outputs expected one cycle after the current inputs
    function automatic logic [13:0] model();
        logic [3:0] s;
        logic [7:0] l;
        int         n;
        int         b;
        s = 4'hF;
        l = 8'hFF;
        n = 1 << wid;
        b = i_addr[2:0] & ~(n - 1);
        if (i_req && i_addr[31:28] < 4)
            s[i_addr[29:28]] = 1'b0;
        for (int k = 0; k < n; k++)
            if (i_req && i_byte_mask[k])
                l[b + k] = 1'b0;
        return {s, l, ~(i_req && i_periph_xfer && i_addr[31:28] < 4),
                i_req && i_write};
    endfunction
    initial
    begin
        {i_mclk, i_rst, i_req, i_write, i_periph_xfer} = 5'h08;
        {i_addr, i_byte_mask, wid} = 42'h0;
        {seed, error_cnt, total_checks, exp_bytes} = {32'd33, 96'd0};
        exp = 14'h3FFE;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int n = 0; n < 400; n++)
        begin
            @(posedge i_mclk);
            i_rst <= n == 200;
            i_req <= n == 1 || $random(seed) % 4 != 0;
            i_write <= 1'($random(seed));
            i_periph_xfer <= n == 1 || $random(seed) % 2 != 0;
            i_addr <= n == 1 ? 32'h1000_0002
                             : {1'b0, 3'($random(seed)), 28'($random(seed))};
            i_byte_mask <= n == 1 ? 8'h01 : 8'($random(seed));
            wid <= n == 1 ? 2'h1 : 2'($random(seed));
            #1;
            if (n == 200 || n == 201)
                exp = 14'h3FFE;
            check({o_space_sel_n, o_lane_en_n, o_periph_xfer_strobe_n,
                   o_write_r}, exp);
            if (exp[13:10] != 4'hF && exp[0])
                exp_bytes += $countones(~exp[9:2]);
            exp = model();
        end
        @(posedge i_mclk);
        i_req <= 1'b0;
        #1;
        check(bytes, exp_bytes);
        check(multi, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
